// >>> core/hdhp_host_port.sv
// Eight-bit asynchronous host port of the digital transceiver.
`timescale 1ns/1ps
`include "hdhp_params.svh"
module hdhp_host_port #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 8
) (
  // Clock and reset.
  input  wire logic              i_mclk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_primary_reset_n,
  input  wire logic              i_secondary_reset_n,
  // Host bus pins.
  input  wire logic              i_port_select_n,
  input  wire logic              i_read_n,
  input  wire logic              i_write_n,
  input  wire logic [ADDR_W-1:0] i_reg_addr_lines,
  input  wire logic [DATA_W-1:0] i_host_data_lines,
  output logic      [DATA_W-1:0] o_host_data_lines,
  output logic                   o_host_data_oe,
  // Open-drain interrupt pin.
  output logic                   o_irq_n,
  output logic                   o_irq_oe,
  // Core status, same clock.
  input  wire logic              i_serial_frame_strobe,
  input  wire logic              i_link_active,
  input  wire logic              i_frame_sync_missing_flag,
  input  wire logic              i_sync_loss_timeout_flag,
  input  wire logic              i_activation_timer_expired_flag,
  input  wire logic              i_signal_absent_flag,
  input  wire logic [DATA_W-1:0] i_rx_gain,
  input  wire logic [DATA_W-1:0] i_noise_margin,
  input  wire logic [15:0]       i_coef_word,
  input  wire logic [DATA_W-1:0] i_activation_state,
  input  wire logic [DATA_W-1:0] i_agc_ffe_gain,
  // Control towards the core.
  output logic      [DATA_W-1:0] o_main_control,
  output logic      [DATA_W-1:0] o_coef_select,
  output logic                   o_coef_readout_enable,
  output logic                   o_hw_mode
);
  // *****************************************************************
  // Elaboration checks.
  // *****************************************************************
  if (ADDR_W != 4 || DATA_W != 8) begin : g_bad_width
    $error("host port supports only a 4-bit address and 8-bit data");
  end

  // *****************************************************************
  // Pin synchronisation.
  // *****************************************************************
  localparam int SW = 5 + ADDR_W + DATA_W;
  logic [SW-1:0] pins_s;
  hdhp_sync #(.WIDTH(SW)) u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_primary_reset_n, i_secondary_reset_n, i_port_select_n,
                 i_read_n, i_write_n, i_reg_addr_lines, i_host_data_lines}),
    .o_sync    (pins_s)
  );

  wire                   rst1_n_s = pins_s[SW-1];
  wire                   rst2_n_s = pins_s[SW-2];
  wire                   cs_n_s   = pins_s[SW-3];
  wire                   rd_n_s   = pins_s[SW-4];
  wire                   wr_n_s   = pins_s[SW-5];
  wire hdhp_pkg::hdhp_addr_t addr_s = pins_s[DATA_W +: ADDR_W];
  wire hdhp_pkg::hdhp_byte_t data_s = pins_s[DATA_W-1:0];

  // *****************************************************************
  // Access decode.
  // *****************************************************************
  logic                  wr_n_prev_q;
  logic                  rd_act_prev_q;
  logic                  fs_prev_q;
  hdhp_pkg::hdhp_access_e acc_type;

  // Register defaults load while both reset pins are held low.
  wire soft_rst  = ~rst1_n_s & ~rst2_n_s;                                       // [RULE16]
  wire hw_mode   = ~cs_n_s & ~rd_n_s & ~wr_n_s;                                 // [RULE2]
  wire rd_act    = ~cs_n_s & ~rd_n_s & wr_n_s;                                  // [RULE1] [RULE3]
  // Writes fire on the strobe's rising edge, chip select still low.
  wire wr_fire   = ~cs_n_s & wr_n_s & ~wr_n_prev_q & rd_n_s;                    // [RULE5]
  // A read ends when its strobe rises; select may rise in the same cycle.
  wire rd_end    = rd_act_prev_q & rd_n_s;
  wire fs_fall   = fs_prev_q & ~i_serial_frame_strobe;
  wire wr_main   = wr_fire & (addr_s == `HDHP_ADDR_MAIN);                       // [RULE18]
  wire wr_mask   = wr_fire & (addr_s == `HDHP_ADDR_MASK);
  wire wr_csel   = wr_fire & (addr_s == `HDHP_ADDR_COEF_LO);
  wire status_rd = rd_end & (addr_s == `HDHP_ADDR_MAIN);                        // [RULE8]

  assign acc_type = hw_mode ? hdhp_pkg::HDHP_ACC_HWMODE :
                    rd_act  ? hdhp_pkg::HDHP_ACC_READ   :
                    (~cs_n_s & ~wr_n_s) ? hdhp_pkg::HDHP_ACC_WRITE :
                    hdhp_pkg::HDHP_ACC_IDLE;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_n_prev_q <= 1'b1;
      rd_act_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
    end else begin
      wr_n_prev_q <= wr_n_s;
      rd_act_prev_q <= rd_act;
      fs_prev_q   <= i_serial_frame_strobe;
    end
  end

  // *****************************************************************
  // Write registers.
  // *****************************************************************
  hdhp_pkg::hdhp_byte_t main_control_q;
  hdhp_pkg::hdhp_byte_t irq_mask_q;
  hdhp_pkg::hdhp_byte_t coef_select_q;

  // Writes to other addresses fall through untouched.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || soft_rst) begin                                           // [RULE16]
      main_control_q <= `HDHP_RST_MAIN;
      irq_mask_q     <= `HDHP_RST_MASK;
      coef_select_q  <= `HDHP_RST_COEF_SEL;
    end else begin
      if (wr_main) main_control_q <= data_s;                                    // [RULE5] [RULE19]
      if (wr_mask) irq_mask_q <= data_s;
      if (wr_csel) coef_select_q <= data_s;                                     // [RULE15]
    end
  end

  // *****************************************************************
  // Status snapshots.
  // *****************************************************************
  // Snapshot values move only on the frame strobe's falling edge, so a
  // host read aligned to that edge never sees a half-updated byte.
  hdhp_pkg::hdhp_byte_t rx_gain_q;
  hdhp_pkg::hdhp_byte_t noise_margin_q;
  hdhp_pkg::hdhp_byte_t activation_q;
  hdhp_pkg::hdhp_byte_t agc_ffe_q;
  logic [15:0]          coef_q;

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || soft_rst) begin
      rx_gain_q      <= 8'h00;
      noise_margin_q <= 8'h00;
      activation_q   <= 8'h00;
      agc_ffe_q      <= 8'h00;
      coef_q         <= 16'h0000;
    end else if (fs_fall) begin
      rx_gain_q      <= i_rx_gain;
      noise_margin_q <= i_noise_margin;
      activation_q   <= i_activation_state;
      agc_ffe_q      <= i_agc_ffe_gain;
      coef_q         <= irq_mask_q[`HDHP_BIT_COEF_EN] ? i_coef_word : 16'h0000;  // [RULE15]
    end
  end

  // *****************************************************************
  // Interrupt sources.
  // *****************************************************************
  wire [`HDHP_NUM_FLAGS-1:0] flags = {i_signal_absent_flag, i_activation_timer_expired_flag,
                                      i_sync_loss_timeout_flag, i_frame_sync_missing_flag,
                                      i_link_active};
  logic [`HDHP_NUM_FLAGS-1:0] flags_prev_q;
  logic [`HDHP_NUM_FLAGS-1:0] flag_evt;
  logic                       irq_pend_q;

  for (genvar g = 0; g < `HDHP_NUM_FLAGS; g++) begin : g_flag
    // The loss-of-signal flag reports both edges, the others rising only.
    wire edge_seen = (g == `HDHP_NUM_FLAGS - 1) ? (flags[g] ^ flags_prev_q[g]) :  // [RULE10]
                                                  (flags[g] & ~flags_prev_q[g]);  // [RULE9]
    assign flag_evt[g] = edge_seen & ~irq_mask_q[g + `HDHP_BIT_ACTIVE];          // [RULE11]
  end

  wire any_evt = |flag_evt;

  // A new event in the clearing cycle keeps the interrupt asserted.
  wire irq_next = any_evt | (irq_pend_q & ~status_rd);                           // [RULE8]

  // The edge history follows the flags through reset, so a flag that is
  // already high when reset lifts raises no interrupt of its own.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst || soft_rst) begin
      flags_prev_q <= flags;
      irq_pend_q   <= 1'b0;
    end else begin
      flags_prev_q <= flags;
      irq_pend_q   <= irq_next;                                                  // [RULE8]
    end
  end

  // *****************************************************************
  // Read mux.
  // *****************************************************************
  wire hdhp_pkg::hdhp_byte_t main_status = {2'b00, flags[4], flags[3], flags[2], flags[1],
                                            flags[0], irq_pend_q};
  hdhp_pkg::hdhp_byte_t rd_mux;
  always_comb begin
    case (addr_s)
      `HDHP_ADDR_MAIN:    rd_mux = main_status;
      `HDHP_ADDR_RXGAIN:  rd_mux = rx_gain_q;
      `HDHP_ADDR_MASK:    rd_mux = noise_margin_q;
      `HDHP_ADDR_COEF_LO: rd_mux = coef_q[7:0];                                 // [RULE14]
      `HDHP_ADDR_COEF_HI: rd_mux = coef_q[15:8];                                // [RULE14]
      `HDHP_ADDR_ACT:     rd_mux = activation_q;
      `HDHP_ADDR_AGCFFE:  rd_mux = agc_ffe_q;
      default:            rd_mux = `HDHP_RSVD_READ;                             // [RULE19]
    endcase
  end

  // *****************************************************************
  // Output flops.
  // *****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_host_data_lines     <= 8'h00;
      o_host_data_oe        <= 1'b0;
      o_irq_n               <= 1'b0;
      o_irq_oe              <= 1'b0;
      o_main_control        <= `HDHP_RST_MAIN;
      o_coef_select         <= `HDHP_RST_COEF_SEL;
      o_coef_readout_enable <= 1'b0;
      o_hw_mode             <= 1'b0;
    end else begin
      o_host_data_lines     <= rd_mux;                                          // [RULE3]
      o_host_data_oe        <= (acc_type == hdhp_pkg::HDHP_ACC_READ);           // [RULE1] [RULE3]
      o_irq_n               <= 1'b0;
      o_irq_oe              <= irq_next;                                        // [RULE7]
      o_main_control        <= main_control_q;
      o_coef_select         <= coef_select_q;
      o_coef_readout_enable <= irq_mask_q[`HDHP_BIT_COEF_EN];
      o_hw_mode             <= hw_mode;                                         // [RULE2]
    end
  end

  // *****************************************************************
  // Assertions.
  // *****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  sequence s_write_edge;
    ~cs_n_s & ~wr_n_s & rd_n_s ##1 ~cs_n_s & wr_n_s & rd_n_s;
  endsequence

  sequence s_status_read;
    rd_act && addr_s == `HDHP_ADDR_MAIN ##1 status_rd;
  endsequence

  read_drive_a: assert property (rd_act |=> o_host_data_oe && // [RULE3]
    o_host_data_lines == $past(rd_mux))
    else $error("read strobe did not drive the data lines");
  read_idle_a: assert property (!rd_act |=> !o_host_data_oe) // [RULE3]
    else $error("data lines driven outside a read");
  select_gate_a: assert property (cs_n_s |=> !o_host_data_oe) // [RULE1]
    else $error("data lines driven without chip select");
  hw_mode_a: assert property (hw_mode |=> o_hw_mode && !o_host_data_oe) // [RULE2]
    else $error("hardware mode not flagged");
  hw_mode_off_a: assert property (!hw_mode |=> !o_hw_mode) // [RULE2]
    else $error("hardware mode flagged without all three pins low");

  write_capture_a: assert property (s_write_edge ##0 // [RULE5]
    (addr_s == `HDHP_ADDR_MAIN && !soft_rst)
    |=> main_control_q == $past(data_s) ##1 o_main_control == $past(data_s, 2))
    else $error("main control write not captured");
  mask_write_a: assert property (wr_mask && !soft_rst |=> irq_mask_q == $past(data_s)) // [RULE5]
    else $error("interrupt mask write not captured");
  csel_write_a: assert property (wr_csel && !soft_rst // [RULE15]
    |=> coef_select_q == $past(data_s))
    else $error("coefficient select write not captured");
  ignore_write_a: assert property (wr_fire && !wr_main && !wr_mask && !wr_csel // [RULE19]
    && !soft_rst |=> $stable(main_control_q) && $stable(irq_mask_q) && $stable(coef_select_q))
    else $error("write to a read-only address changed a register");

  irq_hold_a: assert property (irq_pend_q && !status_rd && !soft_rst // [RULE8]
    |=> irq_pend_q && o_irq_oe)
    else $error("interrupt released without status read");
  irq_release_a: assert property (s_status_read ##0 (!any_evt && !soft_rst) // [RULE8]
    |=> !irq_pend_q && !o_irq_oe)
    else $error("status read did not release interrupt");
  pend_set_a: assert property (any_evt && !soft_rst |=> irq_pend_q && o_irq_oe) // [RULE7]
    else $error("interrupt event was not latched");
  rise_irq_a: assert property ($rose(i_link_active) && !soft_rst // [RULE7] [RULE9]
    && !irq_mask_q[`HDHP_BIT_ACTIVE] |=> o_irq_oe && !o_irq_n)
    else $error("rising link flag raised no interrupt");
  los_any_a: assert property ($fell(i_signal_absent_flag) && !soft_rst // [RULE10]
    && !irq_mask_q[`HDHP_BIT_LOS] |=> irq_pend_q)
    else $error("loss-of-signal fall raised no interrupt");
  los_rise_a: assert property ($rose(i_signal_absent_flag) && !soft_rst // [RULE10]
    && !irq_mask_q[`HDHP_BIT_LOS] |=> irq_pend_q)
    else $error("loss-of-signal rise raised no interrupt");
  mask_block_a: assert property (!irq_pend_q && !soft_rst // [RULE11]
    && (&irq_mask_q[`HDHP_BIT_LOS:`HDHP_BIT_ACTIVE]) |=> !irq_pend_q)
    else $error("masked flag raised interrupt");

  coef_snap_a: assert property (fs_fall && irq_mask_q[`HDHP_BIT_COEF_EN] && !soft_rst // [RULE15]
    |=> coef_q == $past(i_coef_word))
    else $error("enabled coefficient not captured on frame strobe");
  coef_gate_a: assert property (fs_fall && !irq_mask_q[`HDHP_BIT_COEF_EN] && !soft_rst // [RULE15]
    |=> coef_q == 16'h0000)
    else $error("coefficient captured while readout disabled");
  coef_low_a: assert property (addr_s == `HDHP_ADDR_COEF_LO // [RULE14]
    |-> rd_mux == coef_q[7:0])
    else $error("coefficient low byte misplaced");
  coef_split_a: assert property (addr_s == `HDHP_ADDR_COEF_HI // [RULE14]
    |-> rd_mux == coef_q[15:8])
    else $error("coefficient high byte misplaced");
  reserved_read_a: assert property (addr_s > `HDHP_ADDR_AGCFFE // [RULE19]
    |-> rd_mux == `HDHP_RSVD_READ)
    else $error("reserved address returned data");
  defaults_a: assert property (soft_rst // [RULE16]
    |=> main_control_q == `HDHP_RST_MAIN && !irq_pend_q)
    else $error("reset pins did not load defaults");
endmodule

// >>> core/hdhp_params.svh
// Constants for the transceiver host port: offsets, fields, defaults, timing.
//
// Behaviour
// (RULE1) Chip select low gates every register access.
// (RULE2) Select, read, write all low: hardware mode.
// (RULE3) Read strobe low drives addressed register outward.
// (RULE4) Host aligns reads to frame strobe falling.
// (RULE5) Write data captured on write strobe rising.
// (RULE6) Host holds data and address across write.
// (RULE7) Open-drain interrupt pulled low on condition.
// (RULE8) Interrupt stays low until main status read.
// (RULE9) Rising link, sync, timeout, timer flags interrupt.
// (RULE10) Any loss-of-signal change raises an interrupt.
// (RULE11) Set mask bit suppresses that flag's interrupt.
// (RULE12) Host write sequence uses addresses 0, 2, 3.
// (RULE13) Host simple read: select, address, strobe pulse.
// (RULE14) Coefficient low byte then high byte addresses.
// (RULE15) Select coefficient, enable readout, then read bytes.
// (RULE16) Both reset pins load all register defaults.
// (RULE17) Host masks reserved bits, writes required values.
// (RULE18) Three write, seven read registers, shared addresses.
// (RULE19) Reserved or read-only writes ignored; reserved reads zero.
`ifndef HDHP_PARAMS_SVH
`define HDHP_PARAMS_SVH

// *****************************************************************
// Register offsets.
// *****************************************************************
`define HDHP_ADDR_MAIN      4'h0
`define HDHP_ADDR_RXGAIN    4'h1
`define HDHP_ADDR_MASK      4'h2
`define HDHP_ADDR_COEF_LO   4'h3
`define HDHP_ADDR_COEF_HI   4'h4
`define HDHP_ADDR_ACT       4'h5
`define HDHP_ADDR_AGCFFE    4'h6

// *****************************************************************
// Field positions; the flag bits are shared by main status and interrupt mask.
// *****************************************************************
`define HDHP_BIT_COEF_EN    0
`define HDHP_BIT_ACTIVE     1
`define HDHP_BIT_FRAME_SYNC_MISSING_FLAG       2
`define HDHP_BIT_SYNC_LOSS_TIMEOUT_FLAG      3
`define HDHP_BIT_ACTIVATION_TIMER_EXPIRED_FLAG       4
`define HDHP_BIT_LOS        5
`define HDHP_NUM_FLAGS      5

// *****************************************************************
// Defaults and constant answers.
// *****************************************************************
`define HDHP_RST_MAIN       8'h00
`define HDHP_RST_MASK       8'h00
`define HDHP_RST_COEF_SEL   8'h00
`define HDHP_RSVD_READ      8'h00

// *****************************************************************
// Timing.
// *****************************************************************
`define HDHP_SYNC_STAGES    2

`endif

// >>> core/hdhp_pkg.sv
// Types shared by the transceiver host port files.
package hdhp_pkg;
  typedef logic [7:0] hdhp_byte_t;
  typedef logic [3:0] hdhp_addr_t;
  typedef enum logic [1:0] {
    HDHP_ACC_IDLE,
    HDHP_ACC_READ,
    HDHP_ACC_WRITE,
    HDHP_ACC_HWMODE
  } hdhp_access_e;
endpackage

// >>> core/hdhp_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module hdhp_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  // Pins in, synchronised out.
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  // Idle pins are high, so both stages rest high to avoid a false strobe.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      meta_q <= '1;
      o_sync <= '1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// >>> sim/hdhp_host_model.sv
// Behavioural host processor for the transceiver's parallel port.
`timescale 1ns/1ps
module hdhp_host_model (
  // Clock.
  input  wire logic       i_mclk,
  // Read answer from the port.
  input  wire logic [7:0] i_rd_data,
  input  wire logic       i_rd_oe,
  // Host bus pins.
  output logic            o_port_select_n,
  output logic            o_read_n,
  output logic            o_write_n,
  output logic [3:0]      o_reg_addr_lines,
  output logic [7:0]      o_host_data_lines
);
  initial begin
    o_port_select_n   = 1'b1;
    o_read_n          = 1'b1;
    o_write_n         = 1'b1;
    o_reg_addr_lines  = 4'h0;
    o_host_data_lines = 8'h00;
  end

  // **************************************************************
  // Bus cycles.
  // **************************************************************
  // Each write strobe level lasts four clocks, since the port sees its pins through two flops.
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic sel);
    @(posedge i_mclk);
    o_port_select_n   <= ~sel;
    o_reg_addr_lines  <= a;
    o_host_data_lines <= d;
    o_write_n         <= 1'b0;
    repeat (4) @(posedge i_mclk);
    o_write_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
    o_port_select_n   <= 1'b1;
    o_host_data_lines <= ~d;
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic sel, output logic [7:0] d,
                    output logic seen);
    int n;
    n    = 0;
    seen = 1'b0;
    d    = 8'h00;
    @(posedge i_mclk);
    o_port_select_n  <= ~sel;
    o_reg_addr_lines <= a;
    o_read_n         <= 1'b0;
    while (seen == 1'b0 && n < 8) begin
      @(posedge i_mclk);
      n++;
      if (i_rd_oe === 1'b1) begin
        seen = 1'b1;
        d    = i_rd_data;
      end
    end
    @(posedge i_mclk);
    o_read_n        <= 1'b1;
    o_port_select_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask

  task automatic hw_on();
    @(posedge i_mclk);
    o_port_select_n <= 1'b0;
    o_read_n        <= 1'b0;
    o_write_n       <= 1'b0;
  endtask

  task automatic hw_off();
    @(posedge i_mclk);
    o_port_select_n <= 1'b1;
    o_read_n        <= 1'b1;
    o_write_n       <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

// >>> sim/hdhp_host_port_tb.sv
// Self-checking bench for the transceiver host port.
`timescale 1ns/1ps
`include "hdhp_params.svh"
module hdhp_host_port_tb;
  logic             mclk, sys_rst, prst_n, srst_n, fs, seen;
  logic [4:0]       flags;
  logic [7:0]       rx_gain, margin, act_st, agc_gain, rdv;
  logic [15:0]      coef;
  wire  logic       sel_n, rd_n, wr_n, dout_oe, irq_n, irq_oe, irq_line, coef_en, hw_mode;
  wire  logic [3:0] addr;
  wire  logic [7:0] hdata, dout, bus, main_ctl, coef_sel;
  int               error_cnt = 0;
  int               check_count = 0;

  // The pull-up holds the interrupt line high whenever the port lets go of it.
  assign irq_line = irq_oe ? irq_n : 1'b1;
  assign bus      = dout_oe ? dout : hdata;

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  hdhp_host_port i_dut (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_primary_reset_n(prst_n),
    .i_secondary_reset_n(srst_n), .i_port_select_n(sel_n), .i_read_n(rd_n),
    .i_write_n(wr_n), .i_reg_addr_lines(addr), .i_host_data_lines(bus),
    .o_host_data_lines(dout), .o_host_data_oe(dout_oe), .o_irq_n(irq_n), .o_irq_oe(irq_oe),
    .i_serial_frame_strobe(fs), .i_link_active(flags[0]),
    .i_frame_sync_missing_flag(flags[1]), .i_sync_loss_timeout_flag(flags[2]),
    .i_activation_timer_expired_flag(flags[3]), .i_signal_absent_flag(flags[4]),
    .i_rx_gain(rx_gain), .i_noise_margin(margin), .i_coef_word(coef),
    .i_activation_state(act_st), .i_agc_ffe_gain(agc_gain), .o_main_control(main_ctl),
    .o_coef_select(coef_sel), .o_coef_readout_enable(coef_en), .o_hw_mode(hw_mode)
  );
  hdhp_host_model u_host (
    .i_mclk(mclk), .i_rd_data(dout), .i_rd_oe(dout_oe), .o_port_select_n(sel_n),
    .o_read_n(rd_n), .o_write_n(wr_n), .o_reg_addr_lines(addr), .o_host_data_lines(hdata)
  );

  // **************************************************************
  // Helpers.
  // **************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    u_host.rd(a, 1'b1, rdv, seen);
    chk({7'h00, seen}, 8'h01, "read answered");
    chk(rdv, exp, what);
  endtask
  task automatic set_flag(input int k, input logic v);
    @(posedge mclk);
    flags[k] <= v;
    idle(3);
  endtask
  // Snapshots only move on the falling frame strobe, so reads never see a half update.
  task automatic frame();
    @(posedge mclk);
    fs <= 1'b1;
    @(posedge mclk);
    fs <= 1'b0;
    idle(3);
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // **************************************************************
  // Scenarios.
  // **************************************************************
  task automatic t_defaults();
    chk(main_ctl, 8'h00, "control default");
    chk(coef_sel, 8'h00, "select default");
    chk({6'h00, coef_en, irq_line}, 8'h01, "readout and irq idle");
    rdchk(`HDHP_ADDR_MAIN, 8'h00, "status after reset");
  endtask
  task automatic t_writes();
    u_host.wr(`HDHP_ADDR_MAIN, 8'ha5, 1'b1);
    chk(main_ctl, 8'ha5, "control write");
    u_host.wr(`HDHP_ADDR_COEF_LO, 8'h3c, 1'b1);
    chk(coef_sel, 8'h3c, "select write");
    u_host.wr(`HDHP_ADDR_MASK, 8'h01, 1'b1);
    chk({7'h00, coef_en}, 8'h01, "readout enable");
    for (int a = 1; a < 16; a++) begin
      if (a != 2 && a != 3) u_host.wr(a[3:0], 8'hff, 1'b1);
    end
    u_host.wr(`HDHP_ADDR_MAIN, 8'h00, 1'b0);
    chk(main_ctl, 8'ha5, "control kept");
    chk(coef_sel, 8'h3c, "select kept");
    chk({7'h00, coef_en}, 8'h01, "mask kept");
  endtask
  task automatic t_reads();
    @(posedge mclk);
    rx_gain  <= 8'h11;
    margin   <= 8'h22;
    act_st   <= 8'h55;
    agc_gain <= 8'h66;
    coef     <= 16'hbeef;
    frame();
    rx_gain <= 8'h77;
    rdchk(`HDHP_ADDR_RXGAIN, 8'h11, "gain snapshot");
    rdchk(4'h2, 8'h22, "noise margin");
    rdchk(`HDHP_ADDR_ACT, 8'h55, "activation");
    rdchk(`HDHP_ADDR_AGCFFE, 8'h66, "agc ffe gain");
    rdchk(`HDHP_ADDR_COEF_LO, 8'hef, "coef low");
    rdchk(`HDHP_ADDR_COEF_HI, 8'hbe, "coef high");
    for (int a = 7; a < 16; a++) begin
      rdchk(a[3:0], 8'h00, "reserved read");
    end
    u_host.rd(`HDHP_ADDR_RXGAIN, 1'b0, rdv, seen);
    chk({7'h00, seen}, 8'h00, "deselected read");
    frame();
    rdchk(`HDHP_ADDR_RXGAIN, 8'h77, "gain refresh");
    u_host.wr(`HDHP_ADDR_MASK, 8'h00, 1'b1);
    frame();
    rdchk(`HDHP_ADDR_COEF_LO, 8'h00, "coef disabled");
  endtask
  task automatic t_hw();
    u_host.hw_on();
    idle(5);
    chk({6'h00, hw_mode, dout_oe}, 8'h02, "hardware mode");
    u_host.hw_off();
    idle(3);
    chk({7'h00, hw_mode}, 8'h00, "hardware mode left");
    chk(main_ctl, 8'ha5, "no write in hardware mode");
  endtask
  task automatic t_irq();
    for (int k = 0; k < 5; k++) begin
      set_flag(k, 1'b1);
      chk({7'h00, irq_line}, 8'h00, "irq on rise");
      rdchk(`HDHP_ADDR_RXGAIN, 8'h77, "other read");
      chk({7'h00, irq_line}, 8'h00, "irq latched");
      rdchk(`HDHP_ADDR_MAIN, {2'b00, 5'h01 << k, 1'b1}, "status");
      chk({7'h00, irq_line}, 8'h01, "irq released");
      set_flag(k, 1'b0);
      chk({7'h00, irq_line}, {7'h00, k != 4}, "irq on fall");
      if (k == 4) rdchk(`HDHP_ADDR_MAIN, 8'h01, "status after fall");
    end
    for (int k = 0; k < 5; k++) begin
      u_host.wr(`HDHP_ADDR_MASK, 8'h02 << k, 1'b1);
      set_flag(k, 1'b1);
      set_flag(k, 1'b0);
      chk({7'h00, irq_line}, 8'h01, "masked flag");
    end
    u_host.wr(`HDHP_ADDR_MASK, 8'h3e, 1'b1);
    set_flag(4, 1'b1);
    set_flag(0, 1'b1);
    chk({7'h00, irq_line}, 8'h01, "all flags masked");
    set_flag(0, 1'b0);
    set_flag(4, 1'b0);
    u_host.wr(`HDHP_ADDR_MASK, 8'h00, 1'b1);
  endtask
  task automatic t_pin_reset();
    set_flag(0, 1'b1);
    prst_n <= 1'b0;
    idle(5);
    chk(main_ctl, 8'ha5, "one reset pin");
    srst_n <= 1'b0;
    idle(5);
    prst_n <= 1'b1;
    srst_n <= 1'b1;
    idle(5);
    chk(main_ctl, 8'h00, "pin reset control");
    chk(coef_sel, 8'h00, "pin reset select");
    chk({7'h00, irq_line}, 8'h01, "pin reset irq");
  endtask

  initial begin
    {sys_rst, prst_n, srst_n, fs, flags} = {3'h7, 6'h00};
    {rx_gain, margin, act_st, agc_gain, coef} = 48'h0;
    idle(6);
    sys_rst <= 1'b0;
    idle(4);
    t_defaults();
    t_writes();
    t_reads();
    t_hw();
    t_irq();
    t_pin_reset();
    conclude();
  end

  initial begin
    idle(20000);
    error_cnt++;
    $display("Error at %0t ns: watchdog expired", $time);
    conclude();
  end
endmodule
